// >>> verilog/gpc_pkg.sv
// Constants shared by the general purpose port with change detection.
// Assumes a 32-bit AXI4-Lite register bus and an eight pin port.
`default_nettype none

package gpc_pkg;

    // Register bus widths
    localparam int unsigned GPC_AW = 8;
    localparam int unsigned GPC_DW = 32;

    // Register byte offsets
    localparam logic [7:0] GPC_OFF_PORT     = 8'h00;
    localparam logic [7:0] GPC_OFF_DIR      = 8'h04;
    localparam logic [7:0] GPC_OFF_LATCH    = 8'h08;
    localparam logic [7:0] GPC_OFF_CTRL     = 8'h0c;
    localparam logic [7:0] GPC_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] GPC_OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] GPC_OFF_MOVE     = 8'h18;
    localparam logic [7:0] GPC_OFF_SNAP     = 8'h1c;

    // Field positions
    localparam int unsigned GPC_CTRL_PUDN_BIT = 0;
    localparam int unsigned GPC_CTRL_CIE_BIT  = 1;
    localparam int unsigned GPC_IRQ_CHG_BIT   = 0;
    localparam int unsigned GPC_STAT_MIS_BIT  = 1;
    localparam int unsigned GPC_CHG_LSB       = 4;
    localparam int unsigned GPC_CHG_PINS      = 4;

    // Reset values
    localparam logic [7:0] GPC_DIR_RST   = 8'hff;
    localparam logic [7:0] GPC_LATCH_RST = 8'h00;
    localparam logic [1:0] GPC_CTRL_RST  = 2'h1;
    localparam logic       GPC_IRQ_RST   = 1'h0;

    // AXI responses
    localparam logic [1:0] GPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] GPC_RESP_SLVERR = 2'h2;

    typedef enum {
        GPC_REG_PORT,
        GPC_REG_DIR,
        GPC_REG_LATCH,
        GPC_REG_CTRL,
        GPC_REG_IRQ_STAT,
        GPC_REG_IRQ_MASK,
        GPC_REG_MOVE,
        GPC_REG_SNAP,
        GPC_REG_NONE
    } gpc_reg_e;

endpackage

`default_nettype wire

// >>> verilog/gpc_sync.sv
// Two flip-flop synchroniser for a vector of pad inputs.
// Assumes the inputs are asynchronous to clk_i.
`default_nettype none

module gpc_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // Only the second stage reads the first
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// >>> verilog/gpc_change_det.sv
// Change detector for the upper pins against a snapshot.
// Assumes synchronised pins and a one-cycle capture strobe.
`default_nettype none

module gpc_change_det #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pins_i,
    input  wire logic [WIDTH-1:0] is_input_i,
    input  wire logic             capture_i,
    output var  logic [WIDTH-1:0] snap_o,
    output var  logic             mismatch_o
);

    logic [WIDTH-1:0] diff;

    // Snapshot taken on each port access
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            snap_o <= '0;
        end
        else if (capture_i)
        begin
            snap_o <= pins_i;
        end
    end

    // Output pins excluded from the compare
    assign diff = (pins_i ^ snap_o) & is_input_i;

    // Per-pin mismatches ORed, cleared on capture
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            mismatch_o <= 1'b0;
        end
        else
        begin
            mismatch_o <= (|diff) & ~capture_i;
        end
    end

endmodule

`default_nettype wire

// >>> verilog/gpc_port.sv
// Eight pin bidirectional port with pull-ups and change interrupt.
// Assumes an AXI4-Lite master on clk_i and asynchronous pads.
//
// What this block does
// - Direction one tristates pin, zero drives latch
// - Latch register reads back latch, not pins
// - One active-low bit enables all pull-ups
// - Output pins never get a pull-up
// - Pull-ups disabled after reset
// - Only upper input pins are compared
// - Compare against snapshot from last port read or write
// - Upper mismatches ORed into change flag
// - Change interrupt can wake from sleep
// - Port access ends mismatch, except move alias
// - Mismatch keeps setting flag until port read or write
`default_nettype none

module gpc_port #(
    parameter int unsigned PINS = 8
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // AXI4-Lite write address
    input  wire logic [gpc_pkg::GPC_AW-1:0] s_axi_awaddr_i,
    input  wire logic                      s_axi_awvalid_i,
    output var  logic                      s_axi_awready_o,
    // AXI4-Lite write data
    input  wire logic [gpc_pkg::GPC_DW-1:0] s_axi_wdata_i,
    input  wire logic [3:0]                s_axi_wstrb_i,
    input  wire logic                      s_axi_wvalid_i,
    output var  logic                      s_axi_wready_o,
    // AXI4-Lite write response
    output var  logic [1:0]                s_axi_bresp_o,
    output var  logic                      s_axi_bvalid_o,
    input  wire logic                      s_axi_bready_i,
    // AXI4-Lite read address
    input  wire logic [gpc_pkg::GPC_AW-1:0] s_axi_araddr_i,
    input  wire logic                      s_axi_arvalid_i,
    output var  logic                      s_axi_arready_o,
    // AXI4-Lite read data
    output var  logic [gpc_pkg::GPC_DW-1:0] s_axi_rdata_o,
    output var  logic [1:0]                s_axi_rresp_o,
    output var  logic                      s_axi_rvalid_o,
    input  wire logic                      s_axi_rready_i,
    // Pads
    input  wire logic [PINS-1:0]           pin_i,
    output var  logic [PINS-1:0]           pin_o,
    output var  logic [PINS-1:0]           pin_oe_o,
    output var  logic [PINS-1:0]           pullup_en_o,
    // System
    input  wire logic                      sleep_i,
    output var  logic                      wake_o,
    output var  logic                      irq_o
);

    import gpc_pkg::*;

    // Address decode shared by read and write paths
    function automatic gpc_reg_e decode(input logic [GPC_AW-1:0] addr);
        gpc_reg_e sel;
        sel = GPC_REG_NONE;
        if (addr[1:0] == 2'h0)
        begin
            unique case (addr)
                GPC_OFF_PORT:     sel = GPC_REG_PORT;
                GPC_OFF_DIR:      sel = GPC_REG_DIR;
                GPC_OFF_LATCH:    sel = GPC_REG_LATCH;
                GPC_OFF_CTRL:     sel = GPC_REG_CTRL;
                GPC_OFF_IRQ_STAT: sel = GPC_REG_IRQ_STAT;
                GPC_OFF_IRQ_MASK: sel = GPC_REG_IRQ_MASK;
                GPC_OFF_MOVE:     sel = GPC_REG_MOVE;
                GPC_OFF_SNAP:     sel = GPC_REG_SNAP;
                default:          sel = GPC_REG_NONE;
            endcase
        end
        return sel;
    endfunction

    localparam int unsigned HI = GPC_CHG_LSB + GPC_CHG_PINS - 1;

    logic [GPC_AW-1:0]   awaddr_q;
    logic [GPC_DW-1:0]   wdata_q;
    logic [3:0]          wstrb_q;
    logic [PINS-1:0]     dir_q;
    logic [PINS-1:0]     latch_q;
    logic [1:0]          ctrl_q;
    logic                chg_flag_q;
    logic                chg_mask_q;
    logic [PINS-1:0]     pins_sync;
    logic [GPC_CHG_PINS-1:0] snap;
    logic                mismatch;
    logic                wr_en;
    logic                rd_en;
    gpc_reg_e            wr_sel;
    gpc_reg_e            rd_sel;
    logic                capture;
    logic                stat_clr;
    logic                wr_lo;
    logic                port_wr;
    logic                port_rd;
    logic [PINS-1:0]     rd_byte;

    // Pad inputs synchronised before any use
    gpc_sync #(
        .WIDTH   (PINS)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i (pin_i),
        .sync_o  (pins_sync)
    );

    assign wr_en  = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;
    assign rd_en  = s_axi_arvalid_i & s_axi_arready_o;
    assign wr_sel = decode(awaddr_q);
    assign rd_sel = decode(s_axi_araddr_i);

    // Low byte lane carries every register
    assign wr_lo  = wr_en & wstrb_q[0];

    // Port register accesses re-capture the snapshot, move alias does not
    assign port_wr = wr_en & (wr_sel == GPC_REG_PORT);
    assign port_rd = rd_en & (rd_sel == GPC_REG_PORT);
    assign capture = port_wr | port_rd;

    gpc_change_det #(
        .WIDTH      (GPC_CHG_PINS)
    ) u_chg (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .pins_i     (pins_sync[HI:GPC_CHG_LSB]),
        .is_input_i (dir_q[HI:GPC_CHG_LSB]),
        .capture_i  (capture),
        .snap_o     (snap),
        .mismatch_o (mismatch)
    );

    // Write address channel
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_awready_o <= 1'b1;
            awaddr_q        <= '0;
        end
        else if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            s_axi_awready_o <= 1'b0;
            awaddr_q        <= s_axi_awaddr_i;
        end
        else if (s_axi_bvalid_o && s_axi_bready_i)
        begin
            s_axi_awready_o <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_wready_o <= 1'b1;
            wdata_q        <= '0;
            wstrb_q        <= '0;
        end
        else if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            s_axi_wready_o <= 1'b0;
            wdata_q        <= s_axi_wdata_i;
            wstrb_q        <= s_axi_wstrb_i;
        end
        else if (s_axi_bvalid_o && s_axi_bready_i)
        begin
            s_axi_wready_o <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= GPC_RESP_OKAY;
        end
        else if (wr_en)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (wr_sel == GPC_REG_NONE) ? GPC_RESP_SLVERR : GPC_RESP_OKAY;
        end
        else if (s_axi_bready_i)
        begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Direction register
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            dir_q <= GPC_DIR_RST;
        end
        else if (wr_lo && wr_sel == GPC_REG_DIR)
        begin
            dir_q <= wdata_q[PINS-1:0];
        end
    end

    // Output latch, written through port, latch or move alias
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            latch_q <= GPC_LATCH_RST;
        end
        else if (wr_lo
                 && (wr_sel == GPC_REG_PORT || wr_sel == GPC_REG_LATCH
                     || wr_sel == GPC_REG_MOVE))
        begin
            latch_q <= wdata_q[PINS-1:0];
        end
    end

    // Control: pull-up disable and change enable
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q <= GPC_CTRL_RST;
        end
        else if (wr_lo && wr_sel == GPC_REG_CTRL)
        begin
            ctrl_q <= wdata_q[1:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            chg_mask_q <= GPC_IRQ_RST;
        end
        else if (wr_lo && wr_sel == GPC_REG_IRQ_MASK)
        begin
            chg_mask_q <= wdata_q[GPC_IRQ_CHG_BIT];
        end
    end

    assign stat_clr = wr_lo & (wr_sel == GPC_REG_IRQ_STAT) & wdata_q[GPC_IRQ_CHG_BIT];

    // Sticky change flag, set wins over write-one-to-clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            chg_flag_q <= GPC_IRQ_RST;
        end
        else if (mismatch)
        begin
            chg_flag_q <= 1'b1;
        end
        else if (stat_clr)
        begin
            chg_flag_q <= 1'b0;
        end
    end

    // Interrupt request gated by enable and mask, wake by sleep and enable
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            irq_o  <= chg_flag_q & chg_mask_q & ctrl_q[GPC_CTRL_CIE_BIT];
            wake_o <= sleep_i & chg_flag_q & ctrl_q[GPC_CTRL_CIE_BIT];
        end
    end

    // Pad drive
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pin_o       <= GPC_LATCH_RST;
            pin_oe_o    <= ~GPC_DIR_RST;
            pullup_en_o <= '0;
        end
        else
        begin
            pin_o       <= latch_q;
            pin_oe_o    <= ~dir_q;
            pullup_en_o <= {PINS{~ctrl_q[GPC_CTRL_PUDN_BIT]}} & dir_q;
        end
    end

    // Read data mux
    always_comb
    begin
        rd_byte = '0;
        unique case (rd_sel)
            GPC_REG_PORT:     rd_byte = pins_sync;
            GPC_REG_MOVE:     rd_byte = pins_sync;
            GPC_REG_DIR:      rd_byte = dir_q;
            GPC_REG_LATCH:    rd_byte = latch_q;
            GPC_REG_CTRL:     rd_byte = {{(PINS-2){1'b0}}, ctrl_q};
            GPC_REG_IRQ_STAT: rd_byte = {{(PINS-2){1'b0}}, mismatch, chg_flag_q};
            GPC_REG_IRQ_MASK: rd_byte = {{(PINS-1){1'b0}}, chg_mask_q};
            GPC_REG_SNAP:     rd_byte = {snap, {GPC_CHG_LSB{1'b0}}};
            GPC_REG_NONE:     rd_byte = '0;
        endcase
    end

    // Read channel
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= GPC_RESP_OKAY;
        end
        else if (rd_en)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= {{(GPC_DW-PINS){1'b0}}, rd_byte};
            s_axi_rresp_o   <= (rd_sel == GPC_REG_NONE) ? GPC_RESP_SLVERR : GPC_RESP_OKAY;
        end
        else if (s_axi_rvalid_o && s_axi_rready_i)
        begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> tb/gpc_pins_model.sv
// Pad model: external keys, weak pull-ups and floating lines.
// Assumes one system clock; undriven, unpulled lines wander.
`default_nettype none

module gpc_pins_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] key_i,
    input  wire logic [7:0] key_en_i,
    output var  logic [7:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] last_q;

    always_ff @(posedge clk_i)
    begin
        last_q <= pad_o;
    end

    // Driver wins, then keys, then pull-up, else inverse of last level
    assign pad_o = (oe_i & pin_o_i)
        | (~oe_i & key_en_i & key_i)
        | (~oe_i & ~key_en_i & pu_i)
        | (~oe_i & ~key_en_i & ~pu_i & ~last_q);
endmodule

`default_nettype wire

// >>> tb/gpc_port_asserts.sv
// Concurrent checks on the port block's pads and bus handshakes.
// Bound into every gpc_port instance; sees its ports only.
`default_nettype none

module gpc_port_asserts #(
    parameter int unsigned PINS = 8
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       s_axi_awvalid_i,
    input  wire logic                       s_axi_awready_o,
    input  wire logic                       s_axi_wvalid_i,
    input  wire logic                       s_axi_wready_o,
    input  wire logic [1:0]                 s_axi_bresp_o,
    input  wire logic                       s_axi_bvalid_o,
    input  wire logic                       s_axi_bready_i,
    input  wire logic                       s_axi_arvalid_i,
    input  wire logic                       s_axi_arready_o,
    input  wire logic [gpc_pkg::GPC_DW-1:0] s_axi_rdata_o,
    input  wire logic                       s_axi_rvalid_o,
    input  wire logic                       s_axi_rready_i,
    input  wire logic [PINS-1:0]            pin_o,
    input  wire logic [PINS-1:0]            pin_oe_o,
    input  wire logic [PINS-1:0]            pullup_en_o,
    input  wire logic                       sleep_i,
    input  wire logic                       wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpc_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_no_pullup_out: assert property ((pin_oe_o & pullup_en_o) == '0)
        else $error("Pull-up on a driven pin");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> pullup_en_o == '0 && pin_oe_o == '0)
        else $error("Pads not quiet after reset");
    a_wake_sleep: assert property (wake_o |-> $past(sleep_i))
        else $error("Wake without sleep");
    a_pin_write: assert property ($changed(pin_o) |-> $past(s_axi_bvalid_o))
        else $error("Pad data changed outside a write");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("Read answer late");
    a_read_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("Read data not held");
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
        else $error("Write answer late");
    a_write_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("Write response not held");
    a_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("Write accepted while busy");
endmodule

bind gpc_port gpc_port_asserts #(.PINS(PINS)) i_gpc_port_asserts (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o),
    .sleep_i(sleep_i), .wake_o(wake_o)
);

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the port with change detection.
// Assumes gpc_pkg, gpc_port, the pad model and the checker compiled first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import gpc_pkg::*;

    logic        clk_i = 0, rst_n_i = 0, sleep = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]  awaddr = 0, araddr = 0, key = 0, ken = 8'hff;
    logic [31:0] wdata = 0, rd_q;
    logic [1:0]  rsp_q;
    logic        awready, wready, bvalid, arready, rvalid, wake, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  pin_o, oe, pu, pad;
    int          errors = 0, total_checks = 0;

    always #2 clk_i = ~clk_i;

    gpc_port #(.PINS(8)) i_gpc_port (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .pin_i(pad), .pin_o(pin_o), .pin_oe_o(oe), .pullup_en_o(pu),
        .sleep_i(sleep), .wake_o(wake), .irq_o(irq)
    );

    gpc_pins_model i_gpc_pins_model (
        .clk_i(clk_i), .pin_o_i(pin_o), .oe_i(oe), .pu_i(pu),
        .key_i(key), .key_en_i(ken), .pad_o(pad)
    );

    task results;
        $display("Checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task limit(input int n);
        if (n >= 40)
        begin
            errors++;
            $display("Error at %0t: no answer", $time);
            results();
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ad, dd;
        n = 0;
        ad = 0;
        dd = 0;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && dd) && n < 40)
        begin
            @(posedge clk_i);
            n++;
            ad = ad || awready;
            dd = dd || wready;
            awvalid <= !ad;
            wvalid <= !dd;
        end
        while (!bvalid && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        limit(n);
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        int n;
        logic ad;
        n = 0;
        ad = 0;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rvalid && n < 40)
        begin
            @(posedge clk_i);
            n++;
            ad = ad || arready;
            arvalid <= !ad;
        end
        limit(n);
        rd_q = rdata;
        rsp_q = rresp;
        rready <= 1'b0;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(32'(rsp_q), 32'(GPC_RESP_OKAY));
        chk(rd_q, exp);
    endtask

    task t_reset;
        chk(32'(pu), 32'h0);
        chk(32'(oe), 32'h0);
        rdc(GPC_OFF_DIR, 32'(GPC_DIR_RST));
        rdc(GPC_OFF_LATCH, 32'(GPC_LATCH_RST));
        rdc(GPC_OFF_CTRL, 32'h1);
    endtask

    task t_dir;
        key <= 8'h3c;
        wr(GPC_OFF_LATCH, 32'ha5, GPC_RESP_OKAY);
        wr(GPC_OFF_DIR, 32'h0f, GPC_RESP_OKAY);
        tick(2);
        chk(32'(oe), 32'hf0);
        chk(32'(pin_o), 32'ha5);
        rdc(GPC_OFF_LATCH, 32'ha5);
        rdc(GPC_OFF_PORT, 32'hac);
    endtask

    task t_pull;
        ken <= 8'hf0;
        wr(GPC_OFF_CTRL, 32'h0, GPC_RESP_OKAY);
        tick(2);
        chk(32'(pu), 32'h0f);
        rdc(GPC_OFF_PORT, 32'haf);
        ken <= 8'hff;
        wr(GPC_OFF_CTRL, 32'h1, GPC_RESP_OKAY);
        tick(2);
        chk(32'(pu), 32'h0);
    endtask

    task t_change;
        int n;
        n = 0;
        wr(GPC_OFF_DIR, 32'hff, GPC_RESP_OKAY);
        wr(GPC_OFF_CTRL, 32'h2, GPC_RESP_OKAY);
        wr(GPC_OFF_IRQ_MASK, 32'h1, GPC_RESP_OKAY);
        key <= 8'h00;
        tick(4);
        rdc(GPC_OFF_PORT, 32'h0);
        wr(GPC_OFF_IRQ_STAT, 32'h1, GPC_RESP_OKAY);
        key <= 8'h10;
        tick(2);
        while (!irq && n < 40)
        begin
            tick(1);
            n++;
        end
        limit(n);
        chk(32'(irq), 32'h1);
        rdc(GPC_OFF_IRQ_STAT, 32'h3);
        wr(GPC_OFF_IRQ_STAT, 32'h1, GPC_RESP_OKAY);
        rdc(GPC_OFF_IRQ_STAT, 32'h3);
        rdc(GPC_OFF_MOVE, 32'h10);
        rdc(GPC_OFF_IRQ_STAT, 32'h3);
        // One port read per event, no polling
        rdc(GPC_OFF_PORT, 32'h10);
        wr(GPC_OFF_IRQ_STAT, 32'h1, GPC_RESP_OKAY);
        rdc(GPC_OFF_IRQ_STAT, 32'h0);
        tick(3);
        chk(32'(irq), 32'h0);
        key <= 8'h11;
        tick(10);
        rdc(GPC_OFF_IRQ_STAT, 32'h0);
        wr(GPC_OFF_LATCH, 32'h0, GPC_RESP_OKAY);
        wr(GPC_OFF_DIR, 32'hef, GPC_RESP_OKAY);
        tick(10);
        rdc(GPC_OFF_IRQ_STAT, 32'h0);
    endtask

    task t_enable;
        int n;
        n = 0;
        wr(GPC_OFF_DIR, 32'hff, GPC_RESP_OKAY);
        wr(GPC_OFF_CTRL, 32'h0, GPC_RESP_OKAY);
        key <= 8'h31;
        tick(10);
        chk(32'(irq), 32'h0);
        rdc(GPC_OFF_IRQ_STAT, 32'h3);
        wr(GPC_OFF_PORT, 32'h5a, GPC_RESP_OKAY);
        rdc(GPC_OFF_IRQ_STAT, 32'h1);
        rdc(GPC_OFF_SNAP, 32'h30);
        rdc(GPC_OFF_LATCH, 32'h5a);
        sleep <= 1'b1;
        wr(GPC_OFF_CTRL, 32'h2, GPC_RESP_OKAY);
        while (!wake && n < 40)
        begin
            tick(1);
            n++;
        end
        limit(n);
        chk(32'(wake), 32'h1);
        tick(2);
        chk(32'(irq), 32'h1);
        wr(GPC_OFF_IRQ_MASK, 32'h0, GPC_RESP_OKAY);
        tick(2);
        chk(32'(irq), 32'h0);
        sleep <= 1'b0;
        tick(3);
        chk(32'(wake), 32'h0);
        rdc(GPC_OFF_PORT, 32'h31);
        wr(GPC_OFF_IRQ_STAT, 32'h1, GPC_RESP_OKAY);
    endtask

    task t_bus;
        rd(8'h20);
        chk(32'(rsp_q), 32'(GPC_RESP_SLVERR));
        chk(rd_q, 32'h0);
        wr(8'h20, 32'hff, GPC_RESP_SLVERR);
        rdc(GPC_OFF_DIR, 32'hff);
    endtask

    initial
    begin
        tick(4);
        rst_n_i <= 1'b1;
        t_reset();
        t_dir();
        t_pull();
        t_change();
        t_enable();
        t_bus();
        results();
    end
endmodule

`default_nettype wire
